/* include/hpd_pkg.sv */
// constants of the host pin and dma configuration registers
package hpd_pkg;

    // ********************************
    // clock and timing
    // ********************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int IRQ_EDGE_PULSE_NS = 40;
    localparam int IRQ_EDGE_PULSE_CYCLES = (IRQ_EDGE_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                           (IRQ_EDGE_PULSE_NS / CLK_PERIOD_NS);

    // ********************************
    // command codes
    // ********************************
    localparam logic [7:0] CMD_HOST_PIN_SETUP_RD = 8'h20;
    localparam logic [7:0] CMD_HOST_PIN_SETUP_WR = 8'hA0;
    localparam logic [7:0] CMD_DMA_SETUP_RD = 8'h21;
    localparam logic [7:0] CMD_DMA_SETUP_WR = 8'hA1;

    // ********************************
    // host_pin_setup fields
    // ********************************
    localparam int HPS_MERGED_IRQ_ROUTING = 9;
    localparam int HPS_DMA_ACK_LEVEL_SELECT = 6;
    localparam int HPS_DMA_REQUEST_LEVEL_SELECT = 5;
    localparam int HPS_CPU_BUS_WIDTH_MSB = 4;
    localparam int HPS_CPU_BUS_WIDTH_LSB = 3;
    localparam int HPS_IRQ_LEVEL_SELECT = 2;
    localparam int HPS_IRQ_EDGE_LEVEL_SELECT = 1;
    localparam int HPS_IRQ_PIN_GLOBAL_ENABLE = 0;
    localparam logic [1:0] CPU_BUS_WIDTH_16 = 2'h1;
    localparam logic HPS_FLAG_RESET = 1'h0;

    // ********************************
    // dma_setup fields
    // ********************************
    localparam int DMS_TRANSFER_COUNT_ENABLE = 7;
    localparam int DMS_BURST_LENGTH_MSB = 6;
    localparam int DMS_BURST_LENGTH_LSB = 5;
    localparam int DMS_DMA_GO = 4;
    localparam int DMS_BUFFER_TYPE_MSB = 3;
    localparam int DMS_BUFFER_TYPE_LSB = 1;
    localparam int DMS_DMA_DIRECTION_SELECT = 0;
    localparam logic [7:0] DMS_LOW_RESET = 8'h00;

    // ********************************
    // reset levels of pins and read data
    // ********************************
    localparam logic PIN_IDLE_RESET = 1'h1;
    localparam logic [15:0] RD_DATA_RESET = 16'h0000;

endpackage

/* include/hpd_irq_if.sv */
// link between the register bank and one interrupt pin driver
`timescale 1ns/100ps
interface hpd_irq_if;
    logic req;
    logic level_sel;
    logic edge_sel;
    logic enable;
    logic pin;

    modport ctrl (
        output req,
        output level_sel,
        output edge_sel,
        output enable,
        input pin
    );

    modport drv (
        input req,
        input level_sel,
        input edge_sel,
        input enable,
        output pin
    );
endinterface

/* rtl/hpd_irq_pin.sv */
// one interrupt pin driver: enable, level or edge signalling, polarity
`timescale 1ns/100ps
module hpd_irq_pin #(
    parameter int PULSE_CYCLES = hpd_pkg::IRQ_EDGE_PULSE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // pin link
    hpd_irq_if.drv link
);
    import hpd_pkg::*;

    localparam int CW = $clog2(PULSE_CYCLES + 1);

    logic req_q;
    logic [CW-1:0] pulse_cnt;
    logic [CW-1:0] next_pulse_cnt;
    logic pin_q;
    logic next_pin;

    wire gated_req = link.enable & link.req;
    wire rise = gated_req & ~req_q;
    wire active = link.edge_sel ? (pulse_cnt != '0) : gated_req;

    // edge mode: fixed pulse on each rising request
    assign next_pulse_cnt = rise ? CW'(PULSE_CYCLES) :
                            (pulse_cnt != '0) ? pulse_cnt - CW'(1) : pulse_cnt;
    // active low when level select is zero
    assign next_pin = link.level_sel ? active : ~active;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_q <= 1'b0;
            pulse_cnt <= '0;
            pin_q <= PIN_IDLE_RESET;
        end else begin
            req_q <= gated_req;
            pulse_cnt <= next_pulse_cnt;
            pin_q <= next_pin;
        end
    end

    assign link.pin = pin_q;

endmodule // hpd_irq_pin

/* rtl/hpd_config_regs.sv */
// host pin and dma configuration register bank with pin conditioning
`timescale 1ns/100ps
module hpd_config_regs (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // command port
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_wdata_i,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    // interrupt sources, already gated by cpu_irq_enable_mask
    input wire logic host_irq_i,
    input wire logic periph_irq_i,
    // dma handshake from the transfer engine
    input wire logic dma_req_i,
    output logic dma_ack_o,
    // pins
    output logic dma_request_line_one_o,
    input wire logic dma_ack_line_one_i,
    output logic irq_pin_one_o,
    output logic irq_pin_two_o,
    // dma setup fields
    output logic transfer_count_enable_o,
    output logic [1:0] burst_length_field_o,
    output logic dma_go_o,
    output logic [2:0] buffer_type_select_o,
    output logic dma_direction_select_o
);
    import hpd_pkg::*;

    // ********************************
    // register storage
    // ********************************
    logic merged_irq_routing;
    logic dma_ack_level_select;
    logic dma_request_level_select;
    logic irq_level_select;
    logic irq_edge_level_select;
    logic irq_pin_global_enable;
    logic [7:0] dma_setup_low;

    // ********************************
    // command decode
    // ********************************
    wire hps_wr = cmd_valid_i & (cmd_code_i == CMD_HOST_PIN_SETUP_WR);
    wire hps_rd = cmd_valid_i & (cmd_code_i == CMD_HOST_PIN_SETUP_RD);
    wire dms_wr = cmd_valid_i & (cmd_code_i == CMD_DMA_SETUP_WR);
    wire dms_rd = cmd_valid_i & (cmd_code_i == CMD_DMA_SETUP_RD);
    wire any_rd = cmd_valid_i & ~cmd_code_i[7];

    // ********************************
    // write data decode
    // ********************************
    logic next_merged_irq_routing;
    logic next_dma_ack_level_select;
    logic next_dma_request_level_select;
    logic next_irq_level_select;
    logic next_irq_edge_level_select;
    logic next_irq_pin_global_enable;
    logic [7:0] next_dma_setup_low;

    assign next_merged_irq_routing = hps_wr ? cmd_wdata_i[HPS_MERGED_IRQ_ROUTING] :
                                     merged_irq_routing;
    assign next_dma_ack_level_select = hps_wr ? cmd_wdata_i[HPS_DMA_ACK_LEVEL_SELECT] :
                                       dma_ack_level_select;
    assign next_dma_request_level_select = hps_wr ? cmd_wdata_i[HPS_DMA_REQUEST_LEVEL_SELECT] :
                                           dma_request_level_select;
    assign next_irq_level_select = hps_wr ? cmd_wdata_i[HPS_IRQ_LEVEL_SELECT] :
                                   irq_level_select;
    assign next_irq_edge_level_select = hps_wr ? cmd_wdata_i[HPS_IRQ_EDGE_LEVEL_SELECT] :
                                        irq_edge_level_select;
    assign next_irq_pin_global_enable = hps_wr ? cmd_wdata_i[HPS_IRQ_PIN_GLOBAL_ENABLE] :
                                        irq_pin_global_enable;
    // only the low byte of dma_setup is stored, the reserved high byte is dropped
    assign next_dma_setup_low = dms_wr ? cmd_wdata_i[7:0] : dma_setup_low;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            merged_irq_routing <= HPS_FLAG_RESET;
            dma_ack_level_select <= HPS_FLAG_RESET;
            dma_request_level_select <= HPS_FLAG_RESET;
            irq_level_select <= HPS_FLAG_RESET;
            irq_edge_level_select <= HPS_FLAG_RESET;
            irq_pin_global_enable <= HPS_FLAG_RESET;
        end else begin
            merged_irq_routing <= next_merged_irq_routing;
            dma_ack_level_select <= next_dma_ack_level_select;
            dma_request_level_select <= next_dma_request_level_select;
            irq_level_select <= next_irq_level_select;
            irq_edge_level_select <= next_irq_edge_level_select;
            irq_pin_global_enable <= next_irq_pin_global_enable;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dma_setup_low <= DMS_LOW_RESET;
        end else begin
            dma_setup_low <= next_dma_setup_low;
        end
    end

    // ********************************
    // read path
    // ********************************
    logic [15:0] hps_view;
    logic [15:0] next_rd_data;

    always_comb begin
        hps_view = 16'h0000;
        hps_view[HPS_MERGED_IRQ_ROUTING] = merged_irq_routing;
        hps_view[HPS_DMA_ACK_LEVEL_SELECT] = dma_ack_level_select;
        hps_view[HPS_DMA_REQUEST_LEVEL_SELECT] = dma_request_level_select;
        hps_view[HPS_CPU_BUS_WIDTH_MSB:HPS_CPU_BUS_WIDTH_LSB] = CPU_BUS_WIDTH_16;
        hps_view[HPS_IRQ_LEVEL_SELECT] = irq_level_select;
        hps_view[HPS_IRQ_EDGE_LEVEL_SELECT] = irq_edge_level_select;
        hps_view[HPS_IRQ_PIN_GLOBAL_ENABLE] = irq_pin_global_enable;
    end

    // reserved high byte of dma_setup reads zero
    wire logic [15:0] dms_view = {8'h00, dma_setup_low};
    // unknown read codes answer with zero
    assign next_rd_data = hps_rd ? hps_view :
                          dms_rd ? dms_view : 16'h0000;

    // read answer stands for one cycle
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_o <= RD_DATA_RESET;
            rd_valid_o <= 1'b0;
        end else begin
            rd_data_o <= next_rd_data;
            rd_valid_o <= any_rd;
        end
    end

    // ********************************
    // dma field outputs
    // ********************************
    // fields straight from the stored low byte
    assign transfer_count_enable_o = dma_setup_low[DMS_TRANSFER_COUNT_ENABLE];
    assign burst_length_field_o = dma_setup_low[DMS_BURST_LENGTH_MSB:DMS_BURST_LENGTH_LSB];
    assign dma_go_o = dma_setup_low[DMS_DMA_GO];
    assign buffer_type_select_o = dma_setup_low[DMS_BUFFER_TYPE_MSB:DMS_BUFFER_TYPE_LSB];
    assign dma_direction_select_o = dma_setup_low[DMS_DMA_DIRECTION_SELECT];

    // ********************************
    // dma request and acknowledge pins
    // ********************************
    logic dreq_q;
    logic dack_meta;
    logic dack_sync;
    wire next_dreq = dma_request_level_select ? dma_req_i : ~dma_req_i;

    // two flops bring the acknowledge pin into the clock domain
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dreq_q <= PIN_IDLE_RESET;
            dack_meta <= PIN_IDLE_RESET;
            dack_sync <= PIN_IDLE_RESET;
        end else begin
            dreq_q <= next_dreq;
            dack_meta <= dma_ack_line_one_i;
            dack_sync <= dack_meta;
        end
    end

    wire ack_decoded = dma_ack_level_select ? dack_sync : ~dack_sync;
    assign dma_request_line_one_o = dreq_q;
    assign dma_ack_o = ack_decoded;

    // ********************************
    // interrupt pins
    // ********************************
    hpd_irq_if irq_one ();
    hpd_irq_if irq_two ();

    // both sources share pin one when routing is merged
    wire merged_req = host_irq_i | periph_irq_i;
    wire pin_one_req = merged_irq_routing ? merged_req : host_irq_i;
    wire pin_two_req = ~merged_irq_routing & periph_irq_i;

    assign irq_one.req = pin_one_req;
    assign irq_one.level_sel = irq_level_select;
    assign irq_one.edge_sel = irq_edge_level_select;
    assign irq_one.enable = irq_pin_global_enable;

    // pin two shares polarity, trigger and enable with pin one
    assign irq_two.req = pin_two_req;
    assign irq_two.level_sel = irq_level_select;
    assign irq_two.edge_sel = irq_edge_level_select;
    assign irq_two.enable = irq_pin_global_enable;

    hpd_irq_pin u_irq_one (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .link(irq_one.drv)
    );

    hpd_irq_pin u_irq_two (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .link(irq_two.drv)
    );

    assign irq_pin_one_o = irq_one.pin;
    assign irq_pin_two_o = irq_two.pin;

endmodule // hpd_config_regs

/* tb/hpd_checker.sv */
// assertion checker of the host pin and dma configuration registers
`timescale 1ns/100ps
module hpd_checker (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // command port
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_wdata_i,
    input wire logic [15:0] rd_data_o,
    input wire logic rd_valid_o,
    // sources and pins
    input wire logic host_irq_i,
    input wire logic periph_irq_i,
    input wire logic dma_req_i,
    input wire logic dma_ack_o,
    input wire logic dma_request_line_one_o,
    input wire logic dma_ack_line_one_i,
    input wire logic irq_pin_one_o,
    input wire logic irq_pin_two_o
);
    import hpd_pkg::*;
    // ********************************
    // shadow of host_pin_setup, cycles since change
    // ********************************
    logic [9:0] hp;
    logic [3:0] qcnt;
    wire logic hp_wr = cmd_valid_i && cmd_code_i == CMD_HOST_PIN_SETUP_WR;
    wire logic qok = qcnt >= 4'h6;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hp <= 10'h000;
            qcnt <= 4'h0;
        end else if (hp_wr) begin
            hp <= cmd_wdata_i[9:0];
            qcnt <= 4'h0;
        end else if (qcnt != 4'hF) begin
            qcnt <= qcnt + 4'h1;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_rd_pulse_due: assert property (cmd_valid_i && !cmd_code_i[7] |=> rd_valid_o)
        else $error("read answer missing");
    a_rd_pulse_cause: assert property (rd_valid_o |-> $past(cmd_valid_i && !cmd_code_i[7]))
        else $error("read answer without read");
    a_width_reads_16: assert property (hp_wr == 1'b0 && cmd_valid_i && cmd_code_i == CMD_HOST_PIN_SETUP_RD
        |=> rd_data_o[4:3] == 2'h1)
        else $error("bus width field wrong");
    a_dma_high_zero: assert property (cmd_valid_i && cmd_code_i == CMD_DMA_SETUP_RD
        |=> rd_data_o[15:8] == 8'h00)
        else $error("dma setup high byte not zero");
    a_dreq_level: assert property (qok |-> dma_request_line_one_o == !($past(dma_req_i) ^ hp[5]))
        else $error("dma request pin level wrong");
    a_dack_decode: assert property (qok |-> dma_ack_o == !($past(dma_ack_line_one_i, 2) ^ hp[6]))
        else $error("dma ack decode wrong");
    a_irq_one_level: assert property (qok && !hp[1]
        |-> irq_pin_one_o == !(($past(host_irq_i | hp[9] & periph_irq_i) & hp[0]) ^ hp[2]))
        else $error("irq pin one level wrong");
    a_irq_two_level: assert property (qok && !hp[1] && !hp[9]
        |-> irq_pin_two_o == !(($past(periph_irq_i) & hp[0]) ^ hp[2]))
        else $error("irq pin two level wrong");
    a_irq_two_idle: assert property (qok && hp[9] |-> irq_pin_two_o == !hp[2])
        else $error("irq pin two not idle");
    a_irq_off_idle: assert property (qok && !hp[0] |-> irq_pin_one_o == !hp[2])
        else $error("disabled irq pin asserted");
    a_irq_edge_pulse: assert property (qok && hp[1] && hp[0] && !hp[9] && $rose(host_irq_i)
        |-> ##2 (irq_pin_one_o == hp[2]) [*4])
        else $error("irq edge pulse wrong");
    c_read: cover property (rd_valid_o);
    c_cfg_write: cover property (hp_wr);
    c_edge: cover property (qok && hp[1] && hp[0] && $rose(host_irq_i));
endmodule // hpd_checker

/* tb/hpd_cpu_model.sv */
// host processor model driving the command port
`timescale 1ns/100ps
module hpd_cpu_model (
    // clock
    input wire logic ref_clk_i,
    // command port
    output logic cmd_valid_o,
    output logic [7:0] cmd_code_o,
    output logic [15:0] cmd_wdata_o
);
    import hpd_pkg::*;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_wdata_o = 16'h0000;
    end
    // one strobe per command, released lines show the inverse
    task automatic issue(input logic [7:0] c, input logic [15:0] d);
        @(posedge ref_clk_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o <= c;
        cmd_wdata_o <= (c == CMD_HOST_PIN_SETUP_WR) ? {d[15:5], CPU_BUS_WIDTH_16, d[2:0]} : d;
        @(posedge ref_clk_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= ~c;
        cmd_wdata_o <= ~d;
        #1;
    endtask
endmodule // hpd_cpu_model

/* tb/tb.sv */
// self-checking testbench of the host pin and dma configuration registers
`timescale 1ns/100ps
module tb;
    import hpd_pkg::*;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cmd_valid_i, rd_valid_o, dma_ack_o, dma_request_line_one_o, irq_pin_one_o, irq_pin_two_o;
    logic host_irq_i = 1'b0, periph_irq_i = 1'b0, dma_req_i = 1'b0, dma_ack_line_one_i = 1'b1;
    logic transfer_count_enable_o, dma_go_o, dma_direction_select_o;
    logic [1:0] burst_length_field_o;
    logic [2:0] buffer_type_select_o;
    logic [7:0] cmd_code_i;
    logic [15:0] cmd_wdata_i, rd_data_o, cfg, d;
    logic [3:0] exp4;
    int fail_count = 0, n_checks = 0;
    wire logic [7:0] fields = {transfer_count_enable_o, burst_length_field_o, dma_go_o, buffer_type_select_o,
        dma_direction_select_o};
    wire logic [3:0] pins = {dma_request_line_one_o, dma_ack_o, irq_pin_one_o, irq_pin_two_o};
    always #5 ref_clk_i = ~ref_clk_i;
    hpd_cpu_model hpd_cpu_model_inst (.ref_clk_i, .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
        .cmd_wdata_o(cmd_wdata_i));
    hpd_config_regs hpd_config_regs_inst (.ref_clk_i, .sys_rst_i, .cmd_valid_i, .cmd_code_i, .cmd_wdata_i,
        .rd_data_o, .rd_valid_o, .host_irq_i, .periph_irq_i, .dma_req_i, .dma_ack_o, .dma_request_line_one_o,
        .dma_ack_line_one_i, .irq_pin_one_o, .irq_pin_two_o, .transfer_count_enable_o, .burst_length_field_o,
        .dma_go_o, .buffer_type_select_o, .dma_direction_select_o);
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        hpd_cpu_model_inst.issue(c, 16'h0000);
        check("rd_valid", {15'h0000, rd_valid_o}, 16'h0001);
        check("rd_data", rd_data_o, e);
    endtask
    // pins expected once inputs are steady: dreq, ack, irq one, irq two
    function automatic logic [3:0] exp_pins(input logic [15:0] c, input logic r, a, h, p);
        logic act1, act2;
        act1 = c[0] & ~c[1] & (h | c[9] & p);
        act2 = c[0] & ~c[1] & ~c[9] & p;
        return {~(r ^ c[5]), ~(a ^ c[6]), ~(act1 ^ c[2]), ~(act2 ^ c[2])};
    endfunction
    initial begin
        void'($urandom(32'h8FC3));
        repeat (10) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rd(CMD_DMA_SETUP_RD, 16'h0000);
        rd(CMD_HOST_PIN_SETUP_RD, 16'h0008);
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 16'hFFFF : 16'($urandom);
            hpd_cpu_model_inst.issue(CMD_DMA_SETUP_WR, d);
            check("dma_fields", {8'h00, fields}, {8'h00, d[7:0]});
            rd(CMD_DMA_SETUP_RD, {8'h00, d[7:0]});
        end
        // unknown codes: the write is ignored, the read answers zero
        hpd_cpu_model_inst.issue(8'hA2, ~d);
        check("dma_fields", {8'h00, fields}, {8'h00, d[7:0]});
        rd(8'h22, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            cfg = 16'($urandom) & 16'h0267;
            hpd_cpu_model_inst.issue(CMD_HOST_PIN_SETUP_WR, cfg);
            rd(CMD_HOST_PIN_SETUP_RD, cfg | 16'h0008);
            repeat (12) begin
                @(posedge ref_clk_i);
                {host_irq_i, periph_irq_i, dma_req_i, dma_ack_line_one_i} <= 4'($urandom);
            end
            repeat (6) @(posedge ref_clk_i);
            #1;
            exp4 = exp_pins(cfg, dma_req_i, dma_ack_line_one_i, host_irq_i, periph_irq_i);
            check("pins", {12'h000, pins}, {12'h000, exp4});
        end
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        fail_count++;
        complete_run();
    end
endmodule // tb
bind hpd_config_regs hpd_checker hpd_checker_inst (.ref_clk_i, .sys_rst_i, .cmd_valid_i, .cmd_code_i,
    .cmd_wdata_i, .rd_data_o, .rd_valid_o, .host_irq_i, .periph_irq_i, .dma_req_i, .dma_ack_o,
    .dma_request_line_one_o, .dma_ack_line_one_i, .irq_pin_one_o, .irq_pin_two_o);
